// File: hdl/smei_pkg.sv
package smei_pkg;
  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_HALTED_FLAG = 12'h104;
  localparam logic [11:0] OFF_RXDONE_FLAG = 12'h110;
  localparam logic [11:0] OFF_BOTHDONE_FLAG = 12'h118;
  localparam logic [11:0] OFF_TXDONE_FLAG = 12'h120;
  localparam logic [11:0] OFF_BEGAN_FLAG = 12'h14c;
  localparam logic [11:0] OFF_SHORTCUT = 12'h200;
  localparam logic [11:0] OFF_IRQ_SET = 12'h304;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h308;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int BIT_HALTED = 1;
  localparam int BIT_RXDONE = 4;
  localparam int BIT_BOTHDONE = 6;
  localparam int BIT_TXDONE = 8;
  localparam int BIT_BEGAN = 19;
  localparam int BIT_END_TO_BEGIN = 17;
  localparam int NUM_EVT = 5;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_IRQ_EN = 32'h0000_0000;
  localparam logic RST_SHORTCUT = 1'b0;
  localparam logic RST_FLAG = 1'b0;
endpackage : smei_pkg

// File: hdl/smei_flag.sv
`timescale 1ns/1ns
module smei_flag
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Event and software access
  input wire logic i_set,
  input wire logic i_wr,
  input wire logic i_wdata,
  // State
  output logic o_flag
);
  logic flag_reg;
  logic flag_next;

  // Hardware set wins over a software write of zero
  assign flag_next = i_set ? 1'b1 : (i_wr ? i_wdata : flag_reg);
  assign o_flag = flag_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      flag_reg <= smei_pkg::RST_FLAG;
    else
      flag_reg <= flag_next;
  end
endmodule : smei_flag

// File: hdl/smei_regs.sv
// Functional notes
// - Shortcut bit links both-done to begin task
// - Halted interrupt enable: write-one-set, readable
// - Receive-done interrupt enable: write-one-set, readable
// - Both-done interrupt enable: write-one-set, readable
// - Transmit-done interrupt enable: write-one-set, readable
// - Began flag set on start; enable settable
// - Both-done only after receive and transmit end
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ns
module smei_regs
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port
  input wire logic [11:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // Events from the serial engine
  input wire logic i_halted,
  input wire logic i_rx_buffer_done,
  input wire logic i_tx_buffer_done,
  input wire logic i_began,
  input wire logic i_begin_task_sw,
  // Task and interrupt outputs
  output logic o_both_buffers_done,
  output logic o_begin_task,
  output logic o_irq
);
  // ---------------------------------------------------------------
  // Event bit layout
  // ---------------------------------------------------------------
  localparam int EVT_POS [smei_pkg::NUM_EVT] = '{smei_pkg::BIT_HALTED, smei_pkg::BIT_RXDONE,
    smei_pkg::BIT_BOTHDONE, smei_pkg::BIT_TXDONE, smei_pkg::BIT_BEGAN};
  localparam logic [11:0] EVT_OFF [smei_pkg::NUM_EVT] = '{smei_pkg::OFF_HALTED_FLAG,
    smei_pkg::OFF_RXDONE_FLAG, smei_pkg::OFF_BOTHDONE_FLAG, smei_pkg::OFF_TXDONE_FLAG,
    smei_pkg::OFF_BEGAN_FLAG};

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // ---------------------------------------------------------------
  // Both-buffers tracking
  // ---------------------------------------------------------------
  // Each end is remembered until the other arrives or a begin task fires, so skewed ends still pair up
  logic rx_seen_reg;
  logic tx_seen_reg;
  logic rx_seen;
  logic tx_seen;
  logic both_pulse;
  assign rx_seen = rx_seen_reg | i_rx_buffer_done;
  assign tx_seen = tx_seen_reg | i_tx_buffer_done;
  assign both_pulse = rx_seen & tx_seen;

  always_ff @(posedge i_clk)
  begin
    if (i_srst || both_pulse || o_begin_task)
    begin
      rx_seen_reg <= 1'b0;
      tx_seen_reg <= 1'b0;
    end
    else
    begin
      rx_seen_reg <= rx_seen;
      tx_seen_reg <= tx_seen;
    end
  end
  assign o_both_buffers_done = both_pulse;

  // ---------------------------------------------------------------
  // Shortcut and begin task
  // ---------------------------------------------------------------
  logic shortcut_reg;
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      shortcut_reg <= smei_pkg::RST_SHORTCUT;
    else if (i_wr && hit(i_addr, smei_pkg::OFF_SHORTCUT))
      shortcut_reg <= i_wdata[smei_pkg::BIT_END_TO_BEGIN];
  end
  assign o_begin_task = i_begin_task_sw | (shortcut_reg & both_pulse);

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  logic [smei_pkg::NUM_EVT-1:0] evt_in;
  logic [smei_pkg::NUM_EVT-1:0] evt_flag;
  assign evt_in = {i_began, i_tx_buffer_done, both_pulse, i_rx_buffer_done, i_halted};

  genvar g;
  generate
    for (g = 0; g < smei_pkg::NUM_EVT; g++)
    begin : g_flag
      smei_flag u_flag
      (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_set(evt_in[g]),
        .i_wr(i_wr && hit(i_addr, EVT_OFF[g])),
        .i_wdata(i_wdata[0]),
        .o_flag(evt_flag[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt enables
  // ---------------------------------------------------------------
  logic [31:0] irq_en_reg;
  logic [31:0] irq_en_next;
  logic [31:0] evt_mask;
  logic [31:0] flag_word;
  logic wr_set;
  logic wr_clr;
  always_comb
  begin
    evt_mask = 32'h0000_0000;
    flag_word = 32'h0000_0000;
    for (int k = 0; k < smei_pkg::NUM_EVT; k++)
    begin
      evt_mask[EVT_POS[k]] = 1'b1;
      flag_word[EVT_POS[k]] = evt_flag[k];
    end
  end
  assign wr_set = i_wr && hit(i_addr, smei_pkg::OFF_IRQ_SET);
  assign wr_clr = i_wr && hit(i_addr, smei_pkg::OFF_IRQ_CLR);
  // Ones set or clear, zeros leave bits alone
  assign irq_en_next = wr_set ? (irq_en_reg | (i_wdata & evt_mask)) :
    (wr_clr ? (irq_en_reg & ~i_wdata) : irq_en_reg);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      irq_en_reg <= smei_pkg::RST_IRQ_EN;
    else
      irq_en_reg <= irq_en_next;
  end
  assign o_irq = |(irq_en_reg & flag_word);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] rdata_reg;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    for (int k = 0; k < smei_pkg::NUM_EVT; k++)
      if (hit(i_addr, EVT_OFF[k]))
        rd_mux = {31'h0000_0000, evt_flag[k]};
    if (hit(i_addr, smei_pkg::OFF_SHORTCUT))
      rd_mux = {14'h0000, shortcut_reg, 17'h0_0000};
    if (hit(i_addr, smei_pkg::OFF_IRQ_SET) || hit(i_addr, smei_pkg::OFF_IRQ_CLR))
      rd_mux = irq_en_reg;
  end
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      rdata_reg <= 32'h0000_0000;
    else if (i_rd)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= 32'h0000_0000;
  end
  assign o_rdata = rdata_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  short_link_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (shortcut_reg && o_both_buffers_done) |-> o_begin_task)
    else $error("shortcut did not begin");
  halted_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata[smei_pkg::BIT_HALTED]) |=> irq_en_reg[smei_pkg::BIT_HALTED])
    else $error("halted enable not set");
  rx_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata[smei_pkg::BIT_RXDONE]) |=> irq_en_reg[smei_pkg::BIT_RXDONE])
    else $error("rx enable not set");
  both_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata[smei_pkg::BIT_BOTHDONE]) |=> irq_en_reg[smei_pkg::BIT_BOTHDONE])
    else $error("both enable not set");
  tx_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata[smei_pkg::BIT_TXDONE]) |=> irq_en_reg[smei_pkg::BIT_TXDONE])
    else $error("tx enable not set");
  began_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_began |=> evt_flag[4])
    else $error("began flag not set");
  both_cause_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_both_buffers_done |-> (rx_seen && tx_seen))
    else $error("both done without both ends");
  zero_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata == 32'h0000_0000) |=> $stable(irq_en_reg))
    else $error("zero write changed enables");
  irq_level_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg[smei_pkg::BIT_BEGAN] && evt_flag[4]) |-> o_irq)
    else $error("irq missing");

  // ---------------------------------------------------------------
  // Enable clear, set and hold checks
  // ---------------------------------------------------------------
  halted_clr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata[smei_pkg::BIT_HALTED]) |=> !irq_en_reg[smei_pkg::BIT_HALTED])
    else $error("halted enable not cleared");

  rx_clr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata[smei_pkg::BIT_RXDONE]) |=> !irq_en_reg[smei_pkg::BIT_RXDONE])
    else $error("rx enable not cleared");

  both_clr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata[smei_pkg::BIT_BOTHDONE]) |=> !irq_en_reg[smei_pkg::BIT_BOTHDONE])
    else $error("both enable not cleared");

  tx_clr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata[smei_pkg::BIT_TXDONE]) |=> !irq_en_reg[smei_pkg::BIT_TXDONE])
    else $error("tx enable not cleared");

  began_clr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata[smei_pkg::BIT_BEGAN]) |=> !irq_en_reg[smei_pkg::BIT_BEGAN])
    else $error("began enable not cleared");

  began_en_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_set && i_wdata[smei_pkg::BIT_BEGAN]) |=> irq_en_reg[smei_pkg::BIT_BEGAN])
    else $error("began enable not set");

  clr_zero_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (wr_clr && i_wdata == 32'h0000_0000) |=> $stable(irq_en_reg))
    else $error("zero clear changed enables");

  // Bits outside the five events must never become enabled
  spare_bits_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg & ~evt_mask) == 32'h0000_0000)
    else $error("spare enable bit set");

  idle_keep_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (!wr_set && !wr_clr) |=> $stable(irq_en_reg))
    else $error("enables moved without write");

  // ---------------------------------------------------------------
  // Flag checks
  // ---------------------------------------------------------------
  halted_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_halted |=> evt_flag[0])
    else $error("halted flag not set");

  rx_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_rx_buffer_done |=> evt_flag[1])
    else $error("rx flag not set");

  both_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_both_buffers_done |=> evt_flag[2])
    else $error("both flag not set");

  tx_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    i_tx_buffer_done |=> evt_flag[3])
    else $error("tx flag not set");

  began_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (evt_flag[4] && !(i_wr && hit(i_addr, smei_pkg::OFF_BEGAN_FLAG))) |=> evt_flag[4])
    else $error("began flag dropped");

  began_quiet_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (!evt_flag[4] && !i_began && !(i_wr && hit(i_addr, smei_pkg::OFF_BEGAN_FLAG)))
    |=> !evt_flag[4])
    else $error("began flag rose alone");

  began_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_wr && hit(i_addr, smei_pkg::OFF_BEGAN_FLAG) && !i_wdata[0] && !i_began)
    |=> !evt_flag[4])
    else $error("began flag not cleared");

  // ---------------------------------------------------------------
  // Interrupt checks
  // ---------------------------------------------------------------
  irq_halted_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg[smei_pkg::BIT_HALTED] && evt_flag[0]) |-> o_irq)
    else $error("halted irq missing");

  irq_rx_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg[smei_pkg::BIT_RXDONE] && evt_flag[1]) |-> o_irq)
    else $error("rx irq missing");

  irq_both_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg[smei_pkg::BIT_BOTHDONE] && evt_flag[2]) |-> o_irq)
    else $error("both irq missing");

  irq_tx_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg[smei_pkg::BIT_TXDONE] && evt_flag[3]) |-> o_irq)
    else $error("tx irq missing");

  irq_masked_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (irq_en_reg == 32'h0000_0000) |-> !o_irq)
    else $error("irq with all masked");

  irq_no_flag_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (evt_flag == '0) |-> !o_irq)
    else $error("irq with no flag");

  // ---------------------------------------------------------------
  // Shortcut and pairing checks
  // ---------------------------------------------------------------
  short_off_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (!shortcut_reg && !i_begin_task_sw) |-> !o_begin_task)
    else $error("begin without link");

  short_wr_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_wr && hit(i_addr, smei_pkg::OFF_SHORTCUT))
    |=> (shortcut_reg == $past(i_wdata[smei_pkg::BIT_END_TO_BEGIN])))
    else $error("shortcut write lost");

  // A lone end must wait for its partner, not fire early
  rx_wait_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rx_buffer_done && !tx_seen && !i_begin_task_sw) |=> rx_seen_reg)
    else $error("rx end forgotten");

  tx_wait_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_tx_buffer_done && !rx_seen && !i_begin_task_sw) |=> tx_seen_reg)
    else $error("tx end forgotten");

  pair_reset_a: assert property (@(posedge i_clk) disable iff (i_srst)
    o_both_buffers_done |=> (!rx_seen_reg && !tx_seen_reg))
    else $error("ends not cleared");

  single_end_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rx_buffer_done && !tx_seen) |-> !o_both_buffers_done)
    else $error("both done from one end");

  // ---------------------------------------------------------------
  // Read path checks
  // ---------------------------------------------------------------
  rd_idle_a: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_rd |=> (o_rdata == 32'h0000_0000))
    else $error("read data without read");

  rd_enable_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && hit(i_addr, smei_pkg::OFF_IRQ_SET)) |=> (o_rdata == $past(irq_en_reg)))
    else $error("enable readback wrong");

  rd_clr_view_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && hit(i_addr, smei_pkg::OFF_IRQ_CLR)) |=> (o_rdata == $past(irq_en_reg)))
    else $error("clear view readback wrong");

  rd_began_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && hit(i_addr, smei_pkg::OFF_BEGAN_FLAG))
    |=> (o_rdata == {31'h0000_0000, $past(evt_flag[4])}))
    else $error("began readback wrong");

  rd_short_a: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_rd && hit(i_addr, smei_pkg::OFF_SHORTCUT))
    |=> (o_rdata[smei_pkg::BIT_END_TO_BEGIN] == $past(shortcut_reg)))
    else $error("shortcut readback wrong");

endmodule : smei_regs

// File: verification/spi_master_event_irq_regs_tb.sv
`timescale 1ns/1ns
module spi_master_event_irq_regs_tb;
  // ----------------------------------------
  // Stimulus, design and counters
  // ----------------------------------------
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] ev = 4'h0;
  logic sw = 1'b0;
  logic [31:0] rdata;
  logic both;
  logic beg;
  logic irq;
  int err_total = 0;
  int checks = 0;
  smei_regs i_dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_halted(ev[3]), .i_rx_buffer_done(ev[2]),
    .i_tx_buffer_done(ev[1]), .i_began(ev[0]), .i_begin_task_sw(sw),
    .o_both_buffers_done(both), .o_begin_task(beg), .o_irq(irq));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk
  task wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe, so sample just past that edge
  task rd_reg(input logic [11:0] a, input logic [31:0] exp, input string msg);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp, msg);
  endtask : rd_reg
  // Event bits: halted, rx end, tx end, began; outputs are combinational pulses
  task evp(input logic [3:0] v, input logic s, input logic eb, input logic et, input string msg);
    @(posedge i_clk);
    ev <= v;
    sw <= s;
    #1;
    chk({31'h0, both}, {31'h0, eb}, msg);
    chk({31'h0, beg}, {31'h0, et}, msg);
    @(posedge i_clk);
    ev <= 4'h0;
    sw <= 1'b0;
  endtask : evp
  task give_verdict;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rd_reg(smei_pkg::OFF_IRQ_SET, 32'h0, "enables after reset");
    rd_reg(smei_pkg::OFF_SHORTCUT, 32'h0, "shortcut after reset");
    rd_reg(smei_pkg::OFF_BEGAN_FLAG, 32'h0, "began flag after reset");
    rd_reg(12'h000, 32'h0, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task t_enables;
    int bits[5];
    logic [31:0] exp;
    bits = '{smei_pkg::BIT_HALTED, smei_pkg::BIT_RXDONE, smei_pkg::BIT_BOTHDONE,
      smei_pkg::BIT_TXDONE, smei_pkg::BIT_BEGAN};
    exp = 32'h0;
    foreach (bits[i])
    begin
      exp[bits[i]] = 1'b1;
      wr_reg(smei_pkg::OFF_IRQ_SET, 32'h1 << bits[i]);
      rd_reg(smei_pkg::OFF_IRQ_SET, exp, "enable set");
      wr_reg(smei_pkg::OFF_IRQ_SET, 32'h0);
      rd_reg(smei_pkg::OFF_IRQ_SET, exp, "zero write kept");
    end
    rd_reg(smei_pkg::OFF_IRQ_CLR, exp, "clear view");
    wr_reg(smei_pkg::OFF_IRQ_CLR, exp);
    rd_reg(smei_pkg::OFF_IRQ_SET, 32'h0, "enable clear");
    $display("test enables done");
  endtask : t_enables
  task t_began_irq;
    evp(4'h1, 1'b0, 1'b0, 1'b0, "began pulse");
    rd_reg(smei_pkg::OFF_BEGAN_FLAG, 32'h1, "began flag set");
    chk({31'h0, irq}, 32'h0, "masked irq");
    wr_reg(smei_pkg::OFF_IRQ_SET, 32'h1 << smei_pkg::BIT_BEGAN);
    #1;
    chk({31'h0, irq}, 32'h1, "unmasked irq");
    wr_reg(smei_pkg::OFF_BEGAN_FLAG, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0, "irq after flag clear");
    evp(4'h8, 1'b0, 1'b0, 1'b0, "halted pulse");
    wr_reg(smei_pkg::OFF_IRQ_SET, 32'h1 << smei_pkg::BIT_HALTED);
    #1;
    chk({31'h0, irq}, 32'h1, "halted irq");
    wr_reg(smei_pkg::OFF_HALTED_FLAG, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0, "halted irq cleared");
    $display("test began irq done");
  endtask : t_began_irq
  task t_both_short;
    evp(4'h4, 1'b0, 1'b0, 1'b0, "rx end alone");
    evp(4'h2, 1'b0, 1'b1, 1'b0, "tx end completes, no link");
    rd_reg(smei_pkg::OFF_BOTHDONE_FLAG, 32'h1, "both flag");
    evp(4'h2, 1'b0, 1'b0, 1'b0, "tx end alone again");
    wr_reg(smei_pkg::OFF_SHORTCUT, 32'h1 << smei_pkg::BIT_END_TO_BEGIN);
    rd_reg(smei_pkg::OFF_SHORTCUT, 32'h1 << smei_pkg::BIT_END_TO_BEGIN, "link readback");
    evp(4'h4, 1'b0, 1'b1, 1'b1, "linked begin");
    evp(4'h6, 1'b0, 1'b1, 1'b1, "same cycle ends linked");
    wr_reg(smei_pkg::OFF_SHORTCUT, 32'h0);
    evp(4'h6, 1'b0, 1'b1, 1'b0, "link off");
    evp(4'h0, 1'b1, 1'b0, 1'b1, "software begin");
    $display("test both and shortcut done");
  endtask : t_both_short
  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    forever #5 i_clk = ~i_clk;
  end
  initial
  begin
    repeat (20) @(posedge i_clk);
    i_srst <= 1'b0;
    t_reset();
    t_enables();
    t_began_irq();
    t_both_short();
    give_verdict();
  end
  // Whole run takes well under 200 cycles; allow ample margin
  initial
  begin
    #20000;
    err_total++;
    give_verdict();
  end
endmodule : spi_master_event_irq_regs_tb
